// >>> logic/temp_alarm_map.svh
/*
 * Constants of the temperature alarm and shutdown controller: register
 * pointers, reset and default values, fault queue counts and pulse width.
 * Assumes it is included by its bare name; definitions only.
 */
`ifndef TEMP_ALARM_MAP_SVH
`define TEMP_ALARM_MAP_SVH
// register pointers
`define PTR_TEMP 8'h00
`define PTR_CFG 8'h01
`define PTR_LOW 8'h02
`define PTR_HIGH 8'h03
`define PTR_NVCFG 8'h11
`define PTR_NVLOW 8'h12
`define PTR_NVHIGH 8'h13
// configuration byte position inside the 16-bit word
`define CFG_MSB 15
`define CFG_LSB 8
// reset and default values
`define PTR_RESET 8'h00
`define TEMP_RESET 16'h0000
`define NVCFG_DEFAULT 8'h00
`define NVLOW_DEFAULT 16'h4B00
`define NVHIGH_DEFAULT 16'h5000
`define ALERT_IDLE_LEVEL 1'h1
// fault queue needs per field code
`define FQ_NEED_0 3'h1
`define FQ_NEED_1 3'h2
`define FQ_NEED_2 3'h4
`define FQ_NEED_3 3'h6
`define FAULT_SAT 3'h6
// single shot alarm pulse width in ref_clk cycles
`define ALERT_PULSE_CYCLES 8'h10
`endif

// >>> logic/temp_alarm_pkg.sv
/*
 * Types of the temperature alarm and shutdown controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package temp_alarm_pkg;
	// measurement sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_EVAL} measState_e;
	// configuration byte, msb first
	typedef struct packed {
		logic oneShot;
		logic [1:0] spare;
		logic [1:0] faultQueue;
		logic polarity;
		logic alarmMode;
		logic shutdown;
	} thermCfg_s;
	// data write request from the serial engine
	typedef struct packed {
		logic strobe;
		logic byteOnly;
		logic [15:0] data;
	} regWrite_s;
	// converter result, asynchronous to ref_clk
	typedef struct packed {
		logic ready;
		logic [15:0] code;
	} adcResult_s;
endpackage : temp_alarm_pkg

// >>> logic/temp_alarm_shutdown_ctrl.sv
/*
 * Alarm, shutdown and single conversion control of a temperature sensor,
 * with the pointer and seven data registers.
 * Assumes a serial engine on ref_clk giving strobes and a converter
 * whose ready and code arrive asynchronously.
 */
`timescale 1ns/10ps
`include "temp_alarm_map.svh"
module temp_alarm_shutdown_ctrl
	import temp_alarm_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// register port from the serial engine
	input wire logic ptrWrite,
	input wire logic [7:0] ptrByte,
	input wire regWrite_s wrReq,
	input wire logic rdStrobe,
	output logic [15:0] rdData,
	output logic ptrReject,
	output logic wrReject,
	// bus events
	input wire logic araAck,
	input wire logic generalCallReset,
	// lock state kept elsewhere
	input wire logic volLocked,
	input wire logic nvLocked,
	// converter handshake
	output logic measReq,
	input wire adcResult_s adcIn,
	// alarm pin
	output logic alertPin
);

	localparam int PULSE_LEN = 16; // equals ALERT_PULSE_CYCLES

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	//--------------------------------------------------------------
	// converter synchroniser
	//--------------------------------------------------------------
	adcResult_s adcMeta_q; // first stage, read by second only
	adcResult_s adcSync_q; // second stage
	logic readyPrev_q; // for edge detection
	logic readyRise;

	// two flops on the asynchronous converter signals
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			adcMeta_q <= '0;
			adcSync_q <= '0;
			readyPrev_q <= 1'h0;
		end else begin
			adcMeta_q <= adcIn;
			adcSync_q <= adcMeta_q;
			readyPrev_q <= adcSync_q.ready;
		end
	end
	assign readyRise = adcSync_q.ready & ~readyPrev_q;

	//--------------------------------------------------------------
	// register storage and decode
	//--------------------------------------------------------------
	logic [7:0] ptr_q; // register select pointer
	logic ptrFresh_q; // pointer loaded since last write
	logic [15:0] temp_q; // temperature reading
	thermCfg_s cfg_q; // live configuration
	thermCfg_s cfg_d;
	logic [15:0] low_q; // live lower limit
	logic [15:0] high_q; // live upper limit
	thermCfg_s nvCfg_q; // stored configuration
	logic [15:0] nvLow_q; // stored lower limit
	logic [15:0] nvHigh_q; // stored upper limit
	logic [15:0] rdData_q;
	logic ptrReject_q;
	logic wrReject_q;
	thermCfg_s cfgNew; // configuration byte being written
	thermCfg_s cfgReload; // stored copy with one shot cleared
	logic ptrValid, selCfg, selLow, selHigh;
	logic selNvCfg, selNvLow, selNvHigh, selVol, selNv;
	logic wrVol, wrNv, cfgWr, writable;
	logic [15:0] rdSel;
	logic gcall;
	logic shutEnter, shutExit, modeToInt, modeInt;
	logic singleDone;

	// merge an 8-bit write into the upper byte only
	function automatic logic [15:0] mergeWord(input logic [15:0] old,
		input regWrite_s req);
		mergeWord = req.byteOnly ? {req.data[15:8], old[7:0]} : req.data;
	endfunction : mergeWord

	assign gcall = generalCallReset;
	// only the seven listed pointer values are accepted
	assign ptrValid = (ptrByte == `PTR_TEMP) | (ptrByte == `PTR_CFG) |
		(ptrByte == `PTR_LOW) | (ptrByte == `PTR_HIGH) |
		(ptrByte == `PTR_NVCFG) | (ptrByte == `PTR_NVLOW) |
		(ptrByte == `PTR_NVHIGH);
	assign selCfg = ptr_q == `PTR_CFG;
	assign selLow = ptr_q == `PTR_LOW;
	assign selHigh = ptr_q == `PTR_HIGH;
	assign selNvCfg = ptr_q == `PTR_NVCFG;
	assign selNvLow = ptr_q == `PTR_NVLOW;
	assign selNvHigh = ptr_q == `PTR_NVHIGH;
	assign selVol = selCfg | selLow | selHigh;
	assign selNv = selNvCfg | selNvLow | selNvHigh;
	// writes need a fresh pointer and an unlocked target
	assign writable = ptrFresh_q &
		((selVol & ~volLocked) | (selNv & ~nvLocked));
	assign wrVol = wrReq.strobe & ptrFresh_q & ~volLocked;
	assign wrNv = wrReq.strobe & ptrFresh_q & ~nvLocked;
	assign cfgWr = wrVol & selCfg;
	// config lives in the first byte, lower byte ignored
	assign cfgNew = wrReq.data[`CFG_MSB:`CFG_LSB];
	assign cfgReload = {1'h0, nvCfg_q[6:0]};
	assign modeInt = cfg_q.alarmMode;
	assign shutEnter = cfgWr & cfgNew.shutdown & ~cfg_q.shutdown;
	assign shutExit = cfgWr & ~cfgNew.shutdown & cfg_q.shutdown;
	assign modeToInt = cfgWr & cfgNew.alarmMode & ~cfg_q.alarmMode;
	// read mux, temperature read only
	assign rdSel = (ptr_q == `PTR_TEMP) ? temp_q :
		selCfg ? {cfg_q, 8'h00} :
		selLow ? low_q :
		selHigh ? high_q :
		selNvCfg ? {nvCfg_q, 8'h00} :
		selNvLow ? nvLow_q :
		selNvHigh ? nvHigh_q : 16'h0000;

	// pointer and write freshness, cleared by reset or general call
	always_ff @(posedge ref_clk) begin
		if (!reset_n || gcall) begin
			ptr_q <= `PTR_RESET;
			ptrFresh_q <= 1'h0;
		end else if (ptrWrite && ptrValid) begin
			ptr_q <= ptrByte;
			ptrFresh_q <= 1'h1;
		end else if (wrReq.strobe) begin
			ptrFresh_q <= 1'h0;
		end
	end

	// answers to the serial engine
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rdData_q <= 16'h0000;
			ptrReject_q <= 1'h0;
			wrReject_q <= 1'h0;
		end else begin
			if (rdStrobe)
				rdData_q <= rdSel;
			ptrReject_q <= ptrWrite & ~ptrValid;
			wrReject_q <= wrReq.strobe & ~writable;
		end
	end

	// one shot request only in shutdown, cleared when done
	always_comb begin
		cfg_d = cfg_q;
		if (cfgWr)
			cfg_d = cfgNew;
		// dropped on shutdown exit, else a normal run never clears it
		cfg_d.oneShot = cfg_d.shutdown & ((cfg_q.oneShot & ~singleDone) |
			(cfgWr & cfgNew.oneShot & cfg_q.shutdown));
	end

	// live registers, reloaded from stored copies
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cfg_q <= thermCfg_s'(`NVCFG_DEFAULT);
			low_q <= `NVLOW_DEFAULT;
			high_q <= `NVHIGH_DEFAULT;
		end else if (gcall) begin
			cfg_q <= cfgReload;
			low_q <= nvLow_q;
			high_q <= nvHigh_q;
		end else begin
			cfg_q <= cfg_d;
			if (wrVol && selLow)
				low_q <= mergeWord(low_q, wrReq);
			if (wrVol && selHigh)
				high_q <= mergeWord(high_q, wrReq);
		end
	end

	// stored copies, no effect until reloaded
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			nvCfg_q <= thermCfg_s'(`NVCFG_DEFAULT);
			nvLow_q <= `NVLOW_DEFAULT;
			nvHigh_q <= `NVHIGH_DEFAULT;
		end else begin
			if (wrNv && selNvCfg)
				nvCfg_q <= cfgNew;
			if (wrNv && selNvLow)
				nvLow_q <= mergeWord(nvLow_q, wrReq);
			if (wrNv && selNvHigh)
				nvHigh_q <= mergeWord(nvHigh_q, wrReq);
		end
	end

	//--------------------------------------------------------------
	// measurement sequencer
	//--------------------------------------------------------------
	measState_e measState_q;
	measState_e measState_d;
	logic measReq_q; // converter request level
	logic oneShotRun_q; // current run is a single shot
	logic startPending_q; // measurement owed after reset
	logic runMeas, launch, capture, abortRun, evalNow;

	// continuous unless shut down; startup and one shot override
	assign runMeas = startPending_q | ~cfg_q.shutdown |
		cfg_q.oneShot;
	assign launch = (measState_q == ST_IDLE) & runMeas &
		~adcSync_q.ready;
	assign capture = (measState_q == ST_CONV) & readyRise;
	assign abortRun = (measState_q == ST_CONV) & cfg_q.shutdown &
		~oneShotRun_q & ~startPending_q & ~readyRise;
	assign evalNow = measState_q == ST_EVAL;
	assign singleDone = evalNow & oneShotRun_q;

	// next state
	always_comb begin
		case (measState_q)
			ST_IDLE: measState_d = launch ? ST_CONV : ST_IDLE;
			ST_CONV: begin
				if (capture)
					measState_d = ST_EVAL;
				else if (abortRun)
					measState_d = ST_IDLE;
				else
					measState_d = ST_CONV;
			end
			ST_EVAL: measState_d = ST_IDLE;
			default: measState_d = ST_IDLE;
		endcase
	end

	// state, request, single shot flag and startup pending
	always_ff @(posedge ref_clk) begin
		if (!reset_n || gcall) begin
			measState_q <= ST_IDLE;
			measReq_q <= 1'h0;
			oneShotRun_q <= 1'h0;
			startPending_q <= 1'h1;
		end else begin
			measState_q <= measState_d;
			if (launch)
				oneShotRun_q <= cfg_q.shutdown & ~startPending_q;
			measReq_q <= launch | (measReq_q & ~capture & ~abortRun);
			if (evalNow)
				startPending_q <= 1'h0;
		end
	end

	// temperature register updates on each capture
	always_ff @(posedge ref_clk) begin
		if (!reset_n)
			temp_q <= `TEMP_RESET;
		else if (capture)
			temp_q <= adcSync_q.code;
	end

	// no new request while shut down without a reason
	property p_no_meas_halt;
		(measState_q == ST_IDLE && cfg_q.shutdown && !cfg_q.oneShot &&
			!startPending_q && !gcall) |=> !measReq_q;
	endproperty
	a_no_meas_halt: assert property (p_no_meas_halt)
		else $error("measurement requested in shutdown");

	// one shot bit drops after its evaluation
	property p_single_clear;
		(singleDone && !cfgWr && !gcall) |=> !cfg_q.oneShot;
	endproperty
	a_single_clear: assert property (p_single_clear)
		else $error("single conversion bit did not clear");

	//--------------------------------------------------------------
	// fault queue
	//--------------------------------------------------------------
	logic [2:0] faultCnt_q; // consecutive faults
	logic [2:0] cntNext;
	logic [2:0] faultNeed;
	logic isHigh, isLow, isFault, validHigh, validLow;

	// limits compared as twos complement
	assign isHigh = $signed(temp_q) >= $signed(high_q);
	assign isLow = $signed(temp_q) <= $signed(low_q);
	assign isFault = isHigh | isLow;
	assign faultNeed = (cfg_q.faultQueue == 2'h0) ? `FQ_NEED_0 :
		(cfg_q.faultQueue == 2'h1) ? `FQ_NEED_1 :
		(cfg_q.faultQueue == 2'h2) ? `FQ_NEED_2 : `FQ_NEED_3;
	assign cntNext = !isFault ? 3'h0 :
		(faultCnt_q == `FAULT_SAT) ? `FAULT_SAT :
		3'(faultCnt_q + 3'h1);
	assign validHigh = evalNow & isHigh & (cntNext >= faultNeed);
	assign validLow = evalNow & isLow & ~isHigh & (cntNext >= faultNeed);

	// counter kept over shutdown, cleared by reset, general call or a clean reading
	always_ff @(posedge ref_clk) begin
		if (!reset_n || gcall)
			faultCnt_q <= 3'h0;
		else if (evalNow)
			faultCnt_q <= cntNext;
	end

	// clean reading empties the counter
	property p_fault_clear;
		(evalNow && !isFault && !gcall) |=> faultCnt_q == 3'h0;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
		else $error("fault counter not cleared");

	// shutdown transitions leave the counter alone
	property p_cnt_keep;
		((shutEnter || shutExit) && !evalNow && !gcall) |=>
			$stable(faultCnt_q);
	endproperty
	a_cnt_keep: assert property (p_cnt_keep)
		else $error("fault counter changed by shutdown");

	//--------------------------------------------------------------
	// alarm output
	//--------------------------------------------------------------
	logic alertActive_q; // alarm asserted
	logic alert_d;
	logic expectLow_q; // next interrupt event is lower
	logic expect_d;
	logic [7:0] pulseCnt_q; // single shot pulse remaining
	logic [7:0] pulse_d;
	logic lastHigh_q; // last reading gave valid upper fault
	logic lastLow_q; // last reading gave valid lower fault
	logic alertPin_q;
	logic clearEv, takeEval, takeExit, takeAny;

	// interrupt clears: any read, alert response, shutdown entry
	assign clearEv = modeInt & (rdStrobe | araAck | shutEnter);
	// only the expected direction arms, starting with upper
	assign takeEval = ~alertActive_q &
		((validHigh & ~expectLow_q) | (validLow & expectLow_q));
	assign takeExit = shutExit & ~alertActive_q &
		((lastHigh_q & ~expectLow_q) | (lastLow_q & expectLow_q));
	assign takeAny = modeInt & (takeEval | takeExit);

	// alarm next state, set wins over clear
	always_comb begin
		alert_d = alertActive_q;
		expect_d = expectLow_q;
		pulse_d = pulseCnt_q;
		if (pulseCnt_q != 8'h00) begin
			pulse_d = 8'(pulseCnt_q - 8'h01);
			if (pulseCnt_q == 8'h01)
				alert_d = 1'h0;
		end
		if (clearEv) begin
			alert_d = 1'h0;
			pulse_d = 8'h00;
		end
		if (modeToInt)
			expect_d = alertActive_q;
		if (!modeInt) begin
			if (validHigh)
				alert_d = 1'h1;
			else if (validLow)
				alert_d = 1'h0;
		end else if (takeAny) begin
			alert_d = 1'h1;
			expect_d = ~expectLow_q;
			pulse_d = singleDone ? `ALERT_PULSE_CYCLES : 8'h00;
		end
	end

	// alarm state, general call clears it
	always_ff @(posedge ref_clk) begin
		if (!reset_n || gcall) begin
			alertActive_q <= 1'h0;
			expectLow_q <= 1'h0;
			pulseCnt_q <= 8'h00;
			lastHigh_q <= 1'h0;
			lastLow_q <= 1'h0;
		end else begin
			alertActive_q <= alert_d;
			expectLow_q <= expect_d;
			pulseCnt_q <= pulse_d;
			if (evalNow) begin
				lastHigh_q <= validHigh;
				lastLow_q <= validLow;
			end
		end
	end

	// pin level follows polarity bit
	always_ff @(posedge ref_clk) begin
		if (!reset_n || gcall)
			alertPin_q <= `ALERT_IDLE_LEVEL;
		else
			alertPin_q <= alert_d ^ ~cfg_d.polarity;
	end

	// upper valid fault arms the interrupt alarm
	property p_int_high;
		(evalNow && modeInt && !expectLow_q && !alertActive_q && isHigh &&
			cntNext >= faultNeed && !gcall) |=> alertActive_q && expectLow_q;
	endproperty
	a_int_high: assert property (p_int_high)
		else $error("upper fault did not raise alarm");

	// interrupt alarm holds without a clearing event
	property p_int_hold;
		(modeInt && alertActive_q && !rdStrobe && !araAck && !cfgWr &&
			!gcall && pulseCnt_q == 8'h00) |=> alertActive_q;
	endproperty
	a_int_hold: assert property (p_int_hold)
		else $error("interrupt alarm dropped on its own");

	// read or alert response clears it next cycle
	property p_int_clear;
		(modeInt && alertActive_q && (rdStrobe || araAck)) |=>
			!alertActive_q;
	endproperty
	a_int_clear: assert property (p_int_clear)
		else $error("interrupt alarm not cleared");

	// lower fault cannot come first
	property p_first_high;
		(evalNow && modeInt && !expectLow_q && !alertActive_q && !isHigh &&
			!cfgWr) |=> !alertActive_q;
	endproperty
	a_first_high: assert property (p_first_high)
		else $error("alarm raised out of order");

	// shutdown entry clears the interrupt alarm
	// a fault taken in the same cycle wins over the clear
	property p_halt_clear;
		(shutEnter && modeInt && !takeEval) |=> !alertActive_q;
	endproperty
	a_halt_clear: assert property (p_halt_clear)
		else $error("shutdown entry left alarm set");

	// comparator alarm ignores accesses and shutdown
	property p_cmp_stable;
		(!modeInt && !evalNow && !gcall && pulseCnt_q == 8'h00) |=>
			$stable(alertActive_q);
	endproperty
	a_cmp_stable: assert property (p_cmp_stable)
		else $error("comparator alarm changed without fault");

	// general call clears alarm and reloads mode
	property p_gcall;
		gcall |=> !alertActive_q &&
			cfg_q.alarmMode == $past(nvCfg_q.alarmMode);
	endproperty
	a_gcall: assert property (p_gcall)
		else $error("general call did not reset alarm");

	// shutdown exit raises a pending expected lower fault
	property p_halt_exit;
		(shutExit && modeInt && !alertActive_q && lastLow_q && expectLow_q &&
			!gcall) |=> alertActive_q;
	endproperty
	a_halt_exit: assert property (p_halt_exit)
		else $error("pending fault not raised on exit");

	// single shot interrupt alarm is a bounded pulse
	sequence s_single_take;
		modeInt && takeEval && singleDone && !gcall;
	endsequence
	sequence s_pulse_end;
		alertActive_q ##[1:PULSE_LEN] !alertActive_q;
	endsequence
	property p_single_pulse;
		s_single_take |=> s_pulse_end;
	endproperty
	a_single_pulse: assert property (p_single_pulse)
		else $error("single shot alarm pulse wrong");

	//--------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------
	assign rdData = rdData_q;
	assign ptrReject = ptrReject_q;
	assign wrReject = wrReject_q;
	assign measReq = measReq_q;
	assign alertPin = alertPin_q;

endmodule : temp_alarm_shutdown_ctrl

// >>> verification/adc_model.sv
/*
 * Converter stand-in that answers the controller's measurement requests.
 * Assumes measReq comes from the controller clock and linkClk runs free.
 */
`timescale 1ns/10ps
module adc_model
	import temp_alarm_pkg::*;
(
	// link clock and request
	input wire logic linkClk,
	input wire logic measReq,
	// value to report
	input wire logic [15:0] tempCode,
	// result towards the controller
	output adcResult_s adcIn
);
	logic [1:0] waitCnt; // link edges since launch
	initial begin
		adcIn = '0;
		waitCnt = 2'h0;
	end
	// ready held until request drops, then stale code scrambled
	always @(posedge linkClk) begin
		if (!measReq) begin
			waitCnt <= 2'h0;
			if (adcIn.ready) begin
				adcIn.ready <= 1'b0;
				adcIn.code <= ~adcIn.code;
			end
		end else if (!adcIn.ready) begin
			if (waitCnt == 2'h2) begin
				adcIn <= {1'b1, tempCode};
			end else begin
				waitCnt <= waitCnt + 2'h1;
			end
		end
	end
endmodule : adc_model

// >>> verification/tb_temp_alarm_shutdown_ctrl.sv
/*
 * Self-checking bench of the alarm and shutdown controller.
 * Assumes the converter stand-in and the package; alert is active low.
 */
`timescale 1ns/10ps
`include "temp_alarm_map.svh"
`define CHECK(nm, e, g) \
	begin \
		nCompared++; \
		if ((g) !== (e)) begin \
			nFail++; \
			$display("Error %s expected %h seen %h", nm, e, g); \
		end \
	end
module tb_temp_alarm_shutdown_ctrl
	import temp_alarm_pkg::*;
;
	// ----------------------------
	// signals
	// ----------------------------
	logic ref_clk, reset_n, linkClk;
	logic ptrWrite, rdStrobe, araAck, generalCallReset;
	logic volLocked, nvLocked, measReq, alertPin, ptrReject, wrReject;
	logic [7:0] ptrByte;
	logic [15:0] rdData, tempCode;
	regWrite_s wrReq;
	adcResult_s adcIn;
	int nFail = 0;
	int nCompared = 0;
	logic [7:0] ptrTab [6] = '{8'h01, 8'h02, 8'h03, 8'h11, 8'h12, 8'h13};
	logic [15:0] rstTab [6] = '{16'h0000, 16'h4B00, 16'h5000,
		16'h0000, 16'h4B00, 16'h5000};
	int needTab [4] = '{1, 2, 4, 6}; // fault counts per queue code
	logic seen; // request seen while it should stay low
	logic [7:0] cnt; // pulse length in cycles
	int k;
	// clocks: controller 4 ns, link 32 ns with unrelated phase
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	initial begin
		linkClk = 1'b0;
		#7;
		forever #16 linkClk = ~linkClk;
	end
	temp_alarm_shutdown_ctrl DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.ptrWrite(ptrWrite), .ptrByte(ptrByte), .wrReq(wrReq),
		.rdStrobe(rdStrobe), .rdData(rdData), .ptrReject(ptrReject),
		.wrReject(wrReject), .araAck(araAck),
		.generalCallReset(generalCallReset), .volLocked(volLocked),
		.nvLocked(nvLocked), .measReq(measReq), .adcIn(adcIn),
		.alertPin(alertPin));
	adc_model conv (.linkClk(linkClk), .measReq(measReq),
		.tempCode(tempCode), .adcIn(adcIn));
	// ----------------------------
	// tasks
	// ----------------------------
	task reportAndStop;
		$display("compared %0d mismatched %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : reportAndStop
	// pointer byte, answer checked one cycle later
	task ptr(input logic [7:0] b, input logic rej);
		@(negedge ref_clk);
		ptrWrite = 1'b1;
		ptrByte = b;
		@(negedge ref_clk);
		ptrWrite = 1'b0;
		`CHECK("ptrReject", rej, ptrReject)
	endtask : ptr
	task wr(input logic [15:0] d, input logic bo, input logic rej);
		@(negedge ref_clk);
		wrReq = {1'b1, bo, d};
		@(negedge ref_clk);
		wrReq.strobe = 1'b0;
		`CHECK("wrReject", rej, wrReject)
	endtask : wr
	task set(input logic [7:0] b, input logic [15:0] d);
		ptr(b, 1'b0);
		wr(d, 1'b0, 1'b0);
	endtask : set
	task rd(input logic [15:0] e);
		@(negedge ref_clk);
		rdStrobe = 1'b1;
		@(negedge ref_clk);
		rdStrobe = 0;
		`CHECK("rdData", e, rdData)
	endtask : rd
	task rdAt(input logic [7:0] b, input logic [15:0] e);
		ptr(b, 1'b0);
		rd(e);
	endtask : rdAt
	task alertIs(input logic e);
		repeat (2) @(negedge ref_clk);
		`CHECK("alertPin", e, alertPin)
	endtask : alertIs
	// n finished measurements, then let evaluation land
	task meas(input int n);
		k = 0;
		for (int i = 0; i < n; i++) begin
			while (measReq !== 1'b1 && k < 3000) begin
				@(negedge ref_clk);
				k++;
			end
			while (measReq !== 1'b0 && k < 3000) begin
				@(negedge ref_clk);
				k++;
			end
		end
		if (k >= 3000) begin
			nFail++;
			$display("Error measReq wait timed out");
			reportAndStop;
		end
		repeat (3) @(negedge ref_clk);
	endtask : meas
	task quiet;
		seen = 1'b0;
		repeat (80) begin
			@(negedge ref_clk);
			seen = seen | (measReq !== 1'b0);
		end
	endtask : quiet
	initial begin
		#300000;
		nFail++;
		$display("Error run timed out");
		reportAndStop;
	end
	// ----------------------------
	// main sequence
	// ----------------------------
	initial begin
		{ptrWrite, rdStrobe, araAck, generalCallReset} = 4'h0;
		{volLocked, nvLocked, reset_n} = 3'h0;
		ptrByte = 8'h00;
		wrReq = '0;
		tempCode = 16'h4C00;
		repeat (3) @(negedge ref_clk);
		reset_n = 1'b1;
		meas(1);
		rd(16'h4C00);
		for (int i = 0; i < 6; i++) rdAt(ptrTab[i], rstTab[i]);
		ptr(8'h04, 1'b1);
		rd(16'h5000);
		set(8'h01, 16'h00FF);
		wr(16'h0100, 1'b0, 1'b1);
		rd(16'h0000);
		ptr(8'h00, 1'b0);
		wr(16'h1234, 1'b0, 1'b1);
		for (int i = 0; i < 2; i++) begin
			{volLocked, nvLocked} = (i == 0) ? 2'b10 : 2'b01;
			ptr((i == 0) ? 8'h02 : 8'h12, 1'b0);
			wr(16'h4000, 1'b0, 1'b1);
			{volLocked, nvLocked} = 2'b00;
			rd(16'h4B00);
		end
		ptr(8'h02, 1'b0);
		wr(16'h4AFF, 1'b1, 1'b0);
		rd(16'h4A00);
		set(8'h02, 16'h4B00);
		set(8'h11, 16'h0300);
		rdAt(8'h01, 16'h0000);
		// comparator mode
		tempCode = 16'h5000;
		meas(2);
		alertIs(1'b0);
		rdAt(8'h00, 16'h5000);
		alertIs(1'b0);
		set(8'h01, 16'h0100);
		alertIs(1'b0);
		set(8'h01, 16'h0000);
		tempCode = 16'h4C00;
		meas(2);
		alertIs(1'b0);
		// interrupt mode entered with alarm active
		set(8'h01, 16'h0200);
		meas(2);
		alertIs(1'b0);
		rd(16'h0200);
		alertIs(1'b1);
		tempCode = 16'h5000;
		meas(2);
		alertIs(1'b1);
		tempCode = 16'h4B00;
		meas(2);
		alertIs(1'b0);
		@(negedge ref_clk);
		araAck = 1'b1;
		@(negedge ref_clk);
		araAck = 1'b0;
		alertIs(1'b1);
		tempCode = 16'h5000;
		meas(2);
		alertIs(1'b0);
		set(8'h01, 16'h0300);
		alertIs(1'b1);
		quiet;
		`CHECK("measReq", 1'b0, seen)
		// single shot in interrupt mode
		tempCode = 16'h4B00;
		set(8'h01, 16'h8300);
		k = 0;
		cnt = 8'h00;
		while (alertPin !== 1'b0 && k < 500) begin
			@(negedge ref_clk);
			k++;
		end
		while (alertPin === 1'b0 && cnt < 8'h40) begin
			@(negedge ref_clk);
			cnt++;
		end
		if (k >= 500 || cnt >= 8'h40) begin
			nFail++;
			$display("Error alertPin wait timed out");
			reportAndStop;
		end
		`CHECK("pulse", `ALERT_PULSE_CYCLES, cnt)
		rdAt(8'h01, 16'h0300);
		// single shot in comparator mode
		tempCode = 16'h5000;
		set(8'h01, 16'h8100);
		meas(1);
		alertIs(1'b0);
		tempCode = 16'h4B00;
		set(8'h01, 16'h8100);
		meas(1);
		alertIs(1'b1);
		set(8'h01, 16'h8000);
		rd(16'h0000);
		meas(2);
		// fault queue codes
		for (int i = 0; i < 4; i++) begin
			set(8'h01, 16'(16'h0800 * i));
			tempCode = 16'h4C00;
			meas(2);
			tempCode = 16'h5000;
			meas(needTab[i] - 1);
			alertIs(1'b1);
			meas(1);
			alertIs(1'b0);
			tempCode = 16'h4C00;
			meas(1);
			tempCode = 16'h4B00;
			meas(needTab[i]);
			alertIs(1'b1);
		end
		// active high polarity, then back; alarm state untouched
		set(8'h01, 16'h1C00);
		alertIs(1'b0);
		tempCode = 16'h5000;
		meas(2);
		alertIs(1'b1);
		set(8'h01, 16'h1800);
		alertIs(1'b0);
		// general call reset
		@(negedge ref_clk);
		generalCallReset = 1'b1;
		@(negedge ref_clk);
		generalCallReset = 1'b0;
		alertIs(1'b1);
		meas(1);
		quiet;
		`CHECK("measReq", 1'b0, seen)
		rd(16'h5000);
		rdAt(8'h01, 16'h0300);
		reportAndStop;
	end
endmodule : tb_temp_alarm_shutdown_ctrl
